// ==== rtl/sleep_wake_pkg.sv ====
// shared types and constants for the sleep/wake sequencer
// assumes a single 250 MHz standby clock domain
package sleep_wake_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned LONG_PRESS_MS = 4000;
   localparam longint unsigned LONG_PRESS_CYCLES = 64'(LONG_PRESS_MS) * 64'(CLK_MHZ) * 64'd1000;
   localparam int unsigned HOLD_W = 30;
   localparam int unsigned DEBOUNCE_CYCLES = 16;
   localparam int unsigned DEB_W = 5;

   // ----------------------------------------------------------------
   // wake source bit positions
   // ----------------------------------------------------------------
   localparam int unsigned WK_LAN = 0;
   localparam int unsigned WK_PME = 1;
   localparam int unsigned WK_PWRSW = 2;
   localparam int unsigned WK_RTC = 3;
   localparam int unsigned WK_SERIAL = 4;
   localparam int unsigned WK_USB = 5;
   localparam int unsigned WK_PCIE = 6;
   localparam int unsigned WK_PS2 = 7;
   localparam int unsigned WK_NUM = 8;

   // sources honoured from every sleep state
   localparam logic [7:0] WK_DEEP_MASK = 8'hCF;
   // every source is honoured from the light sleep states
   localparam logic [7:0] WK_LIGHT_MASK = 8'hFF;

   // ----------------------------------------------------------------
   // power states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      PS_S0 = 3'h0,
      PS_S1 = 3'h1,
      PS_S3 = 3'h3,
      PS_S4 = 3'h4,
      PS_S5 = 3'h5
   } power_state_t;

   // request from the operating system
   typedef struct packed
   {
      logic valid;
      power_state_t target;
   } os_request_t;

   // rail and domain enables driven out
   typedef struct packed
   {
      logic main_rails;
      logic cpu_run;
      logic dev_power;
      logic usb_power;
      logic wake_logic;
   } power_ctl_t;

endpackage

// ==== rtl/press_timer.sv ====
// power switch press timer: debounces and measures hold time
// assumes sw_level is already synchronised to clk
`timescale 1ns/100ps
`default_nettype none
module press_timer
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sw_level,
   output logic short_press,
   output logic long_press
);
   import sleep_wake_pkg::*;

   localparam logic [HOLD_W-1:0] LONG_LIMIT = HOLD_W'(LONG_PRESS_CYCLES);
   localparam logic [DEB_W-1:0] DEB_LIMIT = DEB_W'(DEBOUNCE_CYCLES);

   logic [DEB_W-1:0] deb_cnt;
   logic pressed;
   logic [HOLD_W-1:0] hold_cnt;
   logic long_done;

   // ----------------------------------------------------------------
   // debounce
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         deb_cnt <= '0;
         pressed <= 1'b0;
      end
      else if (sw_level == pressed)
         deb_cnt <= '0;
      else if (deb_cnt == DEB_LIMIT)
      begin
         deb_cnt <= '0;
         pressed <= sw_level;
      end
      else
         deb_cnt <= deb_cnt + DEB_W'(1);
   end

   // ----------------------------------------------------------------
   // hold measurement
   // ----------------------------------------------------------------
   // hold time counter
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hold_cnt <= '0;
         long_done <= 1'b0;
         short_press <= 1'b0;
         long_press <= 1'b0;
      end
      else
      begin
         short_press <= 1'b0;
         long_press <= 1'b0;
         if (pressed)
         begin
            if (!long_done && hold_cnt == LONG_LIMIT - HOLD_W'(1))
            begin
               long_done <= 1'b1; // fires while still held
               long_press <= 1'b1;
            end
            else if (!long_done)
               hold_cnt <= hold_cnt + HOLD_W'(1);
         end
         else
         begin
            // short press reported on release
            if (hold_cnt != '0 && !long_done)
               short_press <= 1'b1;
            hold_cnt <= '0;
            long_done <= 1'b0;
         end
      end
   end

endmodule // press_timer
`default_nettype wire

// ==== rtl/sleep_wake_sequencer.sv ====
// system sleep/wake sequencer: power state machine with switch and wake sources
// assumes an always-on standby clock; all wake and switch pins are asynchronous
//
// Overview of operation
// - soft-off plus short press powers on
// - working plus short press enters sleep
// - working plus long press forces soft-off
// - sleeping plus short press wakes up
// - sleeping plus long press goes soft-off
// - wake sources qualified by sleep state
// - usb wakes only from S1, S3
// - usb ports off in S4, S5
// - pcie wake gated by firmware enable
// - operating system can command soft-off
// - one switch for power and sleep
// - S4-S5 only wake logic powered, S3 adds usb
// - pcie wake exits S1 to S5
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_sequencer
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pwr_sw_n,
   input wire logic [7:0] wake_in,
   input wire logic pcie_wake_en,
   input wire sleep_wake_pkg::power_state_t sleep_type,
   input wire sleep_wake_pkg::os_request_t os_req,
   output sleep_wake_pkg::power_state_t cur_state,
   output sleep_wake_pkg::power_ctl_t power_ctl,
   output logic wake_event,
   output logic [7:0] wake_source
);
   import sleep_wake_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic reset_n;

   // two flops release the asynchronous reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta <= 1'b0;
         reset_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         reset_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic sw_meta;
   logic sw_sync;
   logic [WK_NUM-1:0] wk_meta;
   logic [WK_NUM-1:0] wk_sync;
   logic en_meta;
   logic en_sync;

   // switch is active low on the pin
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
         en_meta <= 1'b0;
         en_sync <= 1'b0;
      end
      else
      begin
         sw_meta <= ~pwr_sw_n;
         sw_sync <= sw_meta;
         en_meta <= pcie_wake_en;
         en_sync <= en_meta;
      end
   end

   // one synchroniser per wake source
   genvar gi;
   generate
      for (gi = 0; gi < WK_NUM; gi++)
      begin : g_wk_sync
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               wk_meta[gi] <= 1'b0;
               wk_sync[gi] <= 1'b0;
            end
            else
            begin
               wk_meta[gi] <= wake_in[gi];
               wk_sync[gi] <= wk_meta[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // switch press timing
   // ----------------------------------------------------------------
   logic short_press;
   logic long_press;

   press_timer u_press_timer
   (
      .clk(clk),
      .reset_n(reset_n),
      .sw_level(sw_sync),
      .short_press(short_press),
      .long_press(long_press)
   );

   // ----------------------------------------------------------------
   // wake qualification
   // ----------------------------------------------------------------
   logic light_sleep;
   logic deep_sleep;
   logic [WK_NUM-1:0] wk_enabled;
   logic [WK_NUM-1:0] wk_qual;
   logic any_wake;

   // light sleeps take every source, deep ones a subset
   assign light_sleep = (cur_state == PS_S1) || (cur_state == PS_S3);
   assign deep_sleep = (cur_state == PS_S4) || (cur_state == PS_S5);

   always_comb
   begin
      wk_enabled = wk_sync;
      wk_enabled[WK_PCIE] = wk_sync[WK_PCIE] & en_sync;
   end

   always_comb
   begin
      if (light_sleep)
         wk_qual = wk_enabled & WK_LIGHT_MASK;
      else if (deep_sleep)
         wk_qual = wk_enabled & WK_DEEP_MASK;
      else
         wk_qual = '0;
   end

   // any qualified source resumes the system
   assign any_wake = |wk_qual;

   // ----------------------------------------------------------------
   // operating system requests
   // ----------------------------------------------------------------
   logic os_target_ok;
   logic os_take;

   // only sleep or off codes may be requested
   assign os_target_ok = (os_req.target == PS_S1) || (os_req.target == PS_S3) || (os_req.target == PS_S4)
      || (os_req.target == PS_S5);

   // an illegal code would leave the state register unencoded
   assign os_take = os_req.valid && os_target_ok;

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   power_state_t next_state;
   logic valid_sleep;

   // other codes fall back to the lightest sleep
   assign valid_sleep = (sleep_type == PS_S1) || (sleep_type == PS_S3) || (sleep_type == PS_S4);

   always_comb
   begin
      next_state = cur_state;
      unique case (cur_state)
         PS_S0:
         begin
            if (long_press)
               next_state = PS_S5;
            else if (short_press)
               next_state = valid_sleep ? sleep_type : PS_S1;
            else if (os_take)
               next_state = os_req.target;
         end
         PS_S1, PS_S3, PS_S4:
         begin
            if (long_press)
               next_state = PS_S5;
            else if (short_press || any_wake)
               next_state = PS_S0;
         end
         PS_S5:
         begin
            if (short_press || any_wake)
               next_state = PS_S0;
         end
         default:
            next_state = PS_S5;
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // reset lands in soft-off
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cur_state <= PS_S5;
      else
         cur_state <= next_state;
   end

   // ----------------------------------------------------------------
   // rail decode for the state being entered
   // ----------------------------------------------------------------
   power_ctl_t next_ctl;
   logic [WK_NUM-1:0] next_source;

   always_comb
   begin
      next_ctl = '{main_rails: 1'b0, cpu_run: 1'b0, dev_power: 1'b0, usb_power: 1'b0, wake_logic: 1'b1};
      unique case (next_state)
         PS_S0:
         begin
            next_ctl.main_rails = 1'b1;
            next_ctl.cpu_run = 1'b1;
            next_ctl.dev_power = 1'b1;
            next_ctl.usb_power = 1'b1;
         end
         PS_S1:
         begin
            // processor stopped, devices stay powered
            next_ctl.main_rails = 1'b1;
            next_ctl.dev_power = 1'b1;
            next_ctl.usb_power = 1'b1;
         end
         PS_S3:
            next_ctl.usb_power = 1'b1; // kept for light-sleep usb wake
         PS_S4, PS_S5:
            next_ctl.wake_logic = 1'b1; // nothing but the wake logic
      endcase
   end

   // switch press reported as the switch source bit
   always_comb
   begin
      next_source = wk_qual;
      if (short_press)
         next_source[WK_PWRSW] = 1'b1;
   end

   // ----------------------------------------------------------------
   // power controls and wake report
   // ----------------------------------------------------------------
   // registered so the rails follow the state in the same cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         power_ctl <= '{main_rails: 1'b0, cpu_run: 1'b0, dev_power: 1'b0, usb_power: 1'b0, wake_logic: 1'b1};
      else
         power_ctl <= next_ctl;
   end

   // pulse and latched source of the wake that resumed
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wake_event <= 1'b0;
         wake_source <= 8'h00;
      end
      else
      begin
         wake_event <= 1'b0;
         if (cur_state != PS_S0 && next_state == PS_S0)
         begin
            wake_event <= 1'b1;
            wake_source <= next_source;
         end
      end
   end

endmodule // sleep_wake_sequencer
`default_nettype wire

// ==== verif/sleep_wake_chk.sv ====
// port checker for the sleep/wake sequencer
// assumes one standby clock and active-low reset
`timescale 1ns/100ps
`default_nettype none
module sleep_wake_chk
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pwr_sw_n,
   input wire logic [7:0] wake_in,
   input wire logic pcie_wake_en,
   input wire sleep_wake_pkg::power_state_t sleep_type,
   input wire sleep_wake_pkg::os_request_t os_req,
   input wire sleep_wake_pkg::power_state_t cur_state,
   input wire sleep_wake_pkg::power_ctl_t power_ctl,
   input wire logic wake_event,
   input wire logic [7:0] wake_source
);
   import sleep_wake_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // cycles since the switch pin was last low, saturating
   logic [4:0] sw_idle_cnt;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sw_idle_cnt <= '0;
      else if (!pwr_sw_n)
         sw_idle_cnt <= '0;
      else if (sw_idle_cnt != 5'h1F)
         sw_idle_cnt <= sw_idle_cnt + 5'h01;
   end
   // power and wake relations
   chk_wake_alive: assert property (power_ctl.wake_logic)
      else $error("wake logic unpowered");
   chk_usb_deep_off: assert property (cur_state inside {PS_S4, PS_S5} |-> !power_ctl.usb_power)
      else $error("usb powered in deep state");
   chk_cpu_only_s0: assert property (power_ctl.cpu_run == (cur_state == PS_S0))
      else $error("cpu run mismatch");
   chk_deep_unpowered: assert property (
      cur_state inside {PS_S3, PS_S4, PS_S5} |-> !power_ctl.main_rails && !power_ctl.dev_power)
      else $error("devices powered in sleep");
   // a settled switch cannot slip a press in ahead of the request
   chk_os_soft_off: assert property (
      cur_state == PS_S0 && os_req.valid && os_req.target == PS_S5 && sw_idle_cnt >= 5'h18 |=> cur_state == PS_S5)
      else $error("soft-off request not taken");
   chk_event_pulse: assert property (wake_event |-> cur_state == PS_S0 ##1 !wake_event)
      else $error("wake pulse wrong");
   chk_deep_no_usb: assert property (
      wake_event && $past(cur_state) inside {PS_S4, PS_S5} |-> wake_source[5:4] == 2'b00)
      else $error("serial or usb woke deep state");
   chk_pcie_gated: assert property (wake_event && wake_source[WK_PCIE] |-> $past(pcie_wake_en, 3))
      else $error("pcie wake while disabled");
   chk_lan_wake: assert property (
      $rose(wake_in[WK_LAN]) && cur_state != PS_S0 && pwr_sw_n |-> ##[1:4] cur_state == PS_S0)
      else $error("lan wake missed");
   cover property (wake_event && wake_source[WK_USB]);
   cover property (wake_event && wake_source[WK_PCIE]);
   cover property (cur_state == PS_S4);
endmodule // sleep_wake_chk
bind sleep_wake_sequencer sleep_wake_chk chk (.clk(clk), .rst_n(rst_n), .pwr_sw_n(pwr_sw_n),
   .wake_in(wake_in), .pcie_wake_en(pcie_wake_en), .sleep_type(sleep_type), .os_req(os_req),
   .cur_state(cur_state), .power_ctl(power_ctl), .wake_event(wake_event), .wake_source(wake_source));
`default_nettype wire

// ==== verif/front_panel_model.sv ====
// front switch and wake pins seen from outside the board logic
// assumes the bench calls its tasks one at a time
`timescale 1ns/100ps
`default_nettype none
module front_panel_model
(
   input wire logic clk,
   output logic pwr_sw_n,
   output logic [7:0] wake_in
);
   initial
   begin
      pwr_sw_n = 1'b1;
      wake_in = 8'h00;
   end
   task automatic press(input int n);
      @(negedge clk) pwr_sw_n = 1'b0;
      repeat (n) @(negedge clk);
      pwr_sw_n = 1'b1;
   endtask
   // one wake line raised as a level
   task automatic pulse(input int b);
      @(negedge clk) wake_in[b] = 1'b1;
      repeat (12) @(negedge clk);
      wake_in[b] = 1'b0;
   endtask
endmodule // front_panel_model
`default_nettype wire

// ==== verif/test_system_sleep_wake_sequencer.sv ====
// self-checking bench for the sleep/wake sequencer
// assumes the front panel model drives switch and wake pins
`timescale 1ns/100ps
`default_nettype none
module test_system_sleep_wake_sequencer;
   import sleep_wake_pkg::*;
   logic clk, rst_n, pwr_sw_n, pcie_wake_en, wake_event;
   logic [7:0] wake_in, wake_source;
   power_state_t sleep_type, cur_state;
   os_request_t os_req;
   power_ctl_t power_ctl;
   int mismatches = 0;
   int n_compared = 0;
   sleep_wake_sequencer uut (.clk(clk), .rst_n(rst_n), .pwr_sw_n(pwr_sw_n), .wake_in(wake_in),
      .pcie_wake_en(pcie_wake_en), .sleep_type(sleep_type), .os_req(os_req), .cur_state(cur_state),
      .power_ctl(power_ctl), .wake_event(wake_event), .wake_source(wake_source));
   front_panel_model far (.clk(clk), .pwr_sw_n(pwr_sw_n), .wake_in(wake_in));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // rails expected per state
   function automatic logic [4:0] exp_ctl(input power_state_t s);
      return {s inside {PS_S0, PS_S1}, s == PS_S0, s inside {PS_S0, PS_S1}, s inside {PS_S0, PS_S1, PS_S3}, 1'b1};
   endfunction
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic expect_state(input power_state_t exp);
      n_compared++;
      if (cur_state !== exp || power_ctl !== exp_ctl(exp))
      begin
         mismatches++;
         $display("unexpected at %0t: state %0d ctl %b", $time, cur_state, power_ctl);
      end
   endtask
   task automatic expect_source(input int b);
      n_compared++;
      if (wake_source !== (8'h01 << b))
      begin
         mismatches++;
         $display("unexpected at %0t: source %b", $time, wake_source);
      end
   endtask
   task automatic expect_event(input logic exp);
      n_compared++;
      if (wake_event !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: wake pulse %b", $time, wake_event);
      end
   endtask
   task automatic await_state(input power_state_t exp);
      int i;
      for (i = 0; i < 200 && cur_state !== exp; i++) @(negedge clk);
      if (i == 200)
      begin
         mismatches++;
         $display("unexpected at %0t: wait for state ran out", $time);
         give_verdict();
      end
      else
         expect_state(exp);
   endtask
   // requests are made only from the working state
   task automatic os_go(input power_state_t t);
      @(negedge clk) os_req = '{1'b1, t};
      @(negedge clk) os_req = '0;
      expect_state(t);
   endtask
   task automatic t_power_on();
      expect_state(PS_S5);
      far.press(40);
      await_state(PS_S0);
      expect_source(WK_PWRSW);
      expect_event(1'b1);
      @(negedge clk);
      expect_event(1'b0);
      $display("power-on test done");
   endtask
   task automatic t_usb_wake();
      os_go(PS_S3);
      far.pulse(WK_USB);
      expect_state(PS_S0);
      expect_source(WK_USB);
      $display("usb wake test done");
   endtask
   task automatic t_deep_refuse();
      os_go(PS_S4);
      far.pulse(WK_USB);
      expect_state(PS_S4);
      far.pulse(WK_SERIAL);
      expect_state(PS_S4);
      far.pulse(WK_PCIE);
      expect_state(PS_S4);
      pcie_wake_en = 1'b1;
      repeat (4) @(negedge clk);
      far.pulse(WK_PCIE);
      expect_state(PS_S0);
      expect_source(WK_PCIE);
      $display("deep state test done");
   endtask
   task automatic t_switch_sleep();
      far.press(40);
      await_state(PS_S1);
      expect_event(1'b0);
      far.press(40);
      await_state(PS_S0);
      expect_source(WK_PWRSW);
      sleep_type = PS_S3;
      far.press(40);
      await_state(PS_S3);
      far.press(40);
      await_state(PS_S0);
      expect_event(1'b1);
      $display("switch sleep test done");
   endtask
   task automatic t_lan_from_off();
      os_go(PS_S5);
      far.pulse(WK_LAN);
      expect_state(PS_S0);
      expect_source(WK_LAN);
      $display("lan wake test done");
   endtask
   initial
   begin
      rst_n = 1'b0;
      pcie_wake_en = 1'b0;
      sleep_type = PS_S1;
      os_req = '0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_power_on();
      t_usb_wake();
      t_deep_refuse();
      t_switch_sleep();
      t_lan_from_off();
      give_verdict();
   end
endmodule // test_system_sleep_wake_sequencer
`default_nettype wire
